// [aqrm_ctrl.sv]
`include "aqrm_defs.svh"
`default_nettype none
// How it works
// - writing zero to reset-control bit 7 triggers a full device soft reset.
// - after a full soft reset the block enters init; bit 6 reads one again.
// - init lasts 500 us; interrupt output toggles at low-power clock rate.
// - writing zero to bit 6 with bit 7 at one resets only measurement-path registers.
// - while converting, only gain, bypass, voltage select and current source settings may change.
// - first sample after a gain change in run mode is marked invalid.
// - voltage select, gain, bypass, current source writes accepted while running.
// - timed standby measures once per standby period, default 10 s.
// - standby cycle continues until another mode command arrives.
// - standby timer runs on the low-power oscillator clock.
// - each timeout measures, raises data-ready interrupt, returns to idle.
// - each standby measurement starts with 2 ms settling, results dropped.
// - in standby only every third sample is reported.
// - data rate is twice chop rate over decimation ratio 1..32768.
// - current ranges use nominal gains 100, 40, 25 and 5.
// - each interrupt pulse lasts eight low-power clock cycles.
// - standby entered only from stop, with start bit and mode pattern 10.
// - status ready bit clears only when the host reads it; the invalid bit is also rewritten by each new report.
module aqrm_ctrl
  import aqrm_pkg::*;
#(
  parameter int INIT_CYC      = `AQ_INIT_CYC,
  parameter int SETTLE_CYC    = `AQ_SETTLE_CYC,
  parameter int CHOP_HALF_CYC = `AQ_CHOP_HALF_CYC,
  parameter int LP_PER_S      = `AQ_LP_PER_S,
  parameter int LP_DIV        = `AQ_LP_DIV
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // serial register port
  input  wire logic        spiCsN,
  input  wire logic        spiSclk,
  input  wire logic        spiMosi,
  output logic             spiMiso,
  output logic             spiMisoOe,
  // converter results
  input  wire logic [15:0] convCurrent,
  input  wire logic [15:0] convVoltage,
  // analog and clock control
  output logic             adcEnable,
  output logic             lpOscSel,
  output logic             measPathRst,
  output logic [6:0]       ampGain,
  output logic [7:0]       gainSel,
  output logic [7:0]       bypassCtl,
  output logic [7:0]       vinSel,
  output logic [7:0]       isrcCtl,
  // interrupt
  output logic             intOut
);
  localparam int IW = $clog2(INIT_CYC + 1);
  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam int LW = $clog2(LP_PER_S + 1);

  aqrm_state_t state_r;
  logic        devRst_r, measRst_r, converting, lpTick, chopTick, outEvt, report;
  logic [IW-1:0] initCnt_r;
  logic [SW-1:0] settleCnt_r;
  logic [LW-1:0] lpCnt_r;
  logic [7:0]    secCnt_r, mode_r, sbPer_r, rdData;
  logic [3:0]    decExp_r;
  logic [14:0]   decCnt_r, ratioM1;
  logic [1:0]    sbCnt_r;
  logic [2:0]    intCnt_r;
  logic          intBusy_r, lpTog_r, skip_r, ready_r, invalid_r, secDone;
  logic [15:0]   curData_r, volData_r;

  // ----------------------------------------------------------------
  // serial port: three-stage sync, agree filter, 16-bit frames
  // ----------------------------------------------------------------
  logic [2:0] s1_r, s2_r, s3_r, filt_r, agree;
  logic       sclkPrev_r, csN, sclk, mosi, rise, fall;
  logic [3:0] bitCnt_r;
  logic [14:0] shIn_r;
  logic [7:0]  shOut_r, wrData;
  logic [6:0]  hdrAddr_r;
  logic        hdrWr_r, rdStb, wrStb;

  assign agree = ~(s2_r ^ s3_r);
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_r   <= 3'h4;
      s2_r   <= 3'h4;
      s3_r   <= 3'h4;
      filt_r <= 3'h4;
    end else begin
      s1_r   <= {spiCsN, spiSclk, spiMosi};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= (s2_r & agree) | (filt_r & ~agree);
    end
  end
  assign csN  = filt_r[2];
  assign sclk = filt_r[1];
  assign mosi = filt_r[0];
  assign rise = !csN && sclk && !sclkPrev_r;
  assign fall = !csN && !sclk && sclkPrev_r;
  assign rdStb  = rise && (bitCnt_r == 4'h7) && !shIn_r[6];
  assign wrStb  = rise && (bitCnt_r == 4'hf) && hdrWr_r;
  assign wrData = {shIn_r[6:0], mosi};

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclkPrev_r <= 1'b0;
      bitCnt_r   <= 4'h0;
      shIn_r     <= 15'h0000;
      shOut_r    <= 8'h00;
      hdrAddr_r  <= 7'h00;
      hdrWr_r    <= 1'b0;
      spiMiso    <= 1'b0;
    end else begin
      sclkPrev_r <= sclk;
      if (csN) begin
        bitCnt_r <= 4'h0;
      end else if (rise) begin
        shIn_r   <= {shIn_r[13:0], mosi};
        bitCnt_r <= bitCnt_r + 4'h1;
        if (bitCnt_r == 4'h7) begin
          hdrWr_r   <= shIn_r[6];
          hdrAddr_r <= {shIn_r[5:0], mosi};
          shOut_r   <= rdData;
        end
      end else if (fall) begin
        spiMiso <= shOut_r[7];
        shOut_r <= {shOut_r[6:0], 1'b0};
      end
    end
  end
  assign spiMisoOe = !csN;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [6:0] rdAddr, wrAddr;
  logic       notInit, liveWr, cfgWr, modeWr, gainChg, statusRd;
  assign rdAddr  = {shIn_r[5:0], mosi};
  assign wrAddr  = hdrAddr_r;
  assign notInit = (state_r != ST_INIT);
  assign liveWr  = wrStb && notInit;
  assign cfgWr   = liveWr && (state_r == ST_STOP);
  assign modeWr  = liveWr && (wrAddr == `AQ_OFS_MODE);
  assign gainChg = liveWr && (wrAddr == `AQ_OFS_GAIN) && (wrData != gainSel);
  assign statusRd = rdStb && (rdAddr == `AQ_OFS_STATUS);

  always_comb begin
    case (rdAddr)
      `AQ_OFS_MODE:   rdData = mode_r;
      `AQ_OFS_STATUS: rdData = {4'h0, state_r == ST_RUN,
                                state_r inside {ST_SB_WAIT, ST_SB_SETTLE, ST_SB_MEAS},
                                invalid_r, ready_r};
      `AQ_OFS_SBPER:  rdData = sbPer_r;
      `AQ_OFS_DEC:    rdData = {4'h0, decExp_r};
      `AQ_OFS_RST:    rdData = `AQ_RST_READ;
      `AQ_OFS_CURH:   rdData = curData_r[15:8];
      `AQ_OFS_CURL:   rdData = curData_r[7:0];
      `AQ_OFS_VOLH:   rdData = volData_r[15:8];
      `AQ_OFS_VOLL:   rdData = volData_r[7:0];
      `AQ_OFS_GAIN:   rdData = gainSel;
      `AQ_OFS_BYP:    rdData = bypassCtl;
      `AQ_OFS_VSEL:   rdData = vinSel;
      `AQ_OFS_ISRC:   rdData = isrcCtl;
      default:        rdData = 8'h00;
    endcase
  end

  // reset-control writes act in any state, init included
  always_ff @(posedge mclk) begin
    if (srst) begin
      devRst_r  <= 1'b0;
      measRst_r <= 1'b0;
    end else begin
      devRst_r  <= wrStb && (wrAddr == `AQ_OFS_RST) && !wrData[`AQ_RST_DEV_BIT];
      measRst_r <= wrStb && (wrAddr == `AQ_OFS_RST) && wrData[`AQ_RST_DEV_BIT]
                   && !wrData[`AQ_RST_MEAS_BIT];
    end
  end
  assign measPathRst = measRst_r;

  always_ff @(posedge mclk) begin
    if (srst || devRst_r) begin
      mode_r  <= 8'h00;
      sbPer_r <= `AQ_SBPER_RST;
    end else begin
      if (modeWr) begin
        mode_r <= wrData;
      end
      if (cfgWr && (wrAddr == `AQ_OFS_SBPER)) begin
        sbPer_r <= wrData;
      end
    end
  end

  // measurement path: cleared by either soft reset, mode register untouched by the measurement-path reset
  always_ff @(posedge mclk) begin
    if (srst || devRst_r || measRst_r) begin
      gainSel   <= 8'h00;
      bypassCtl <= 8'h00;
      vinSel    <= 8'h00;
      isrcCtl   <= 8'h00;
      decExp_r  <= `AQ_DEC_EXP_RST;
    end else begin
      if (liveWr && (wrAddr == `AQ_OFS_GAIN)) gainSel <= wrData;
      if (liveWr && (wrAddr == `AQ_OFS_BYP))  bypassCtl <= wrData;
      if (liveWr && (wrAddr == `AQ_OFS_VSEL)) vinSel <= wrData;
      if (liveWr && (wrAddr == `AQ_OFS_ISRC)) isrcCtl <= wrData;
      if (cfgWr && (wrAddr == `AQ_OFS_DEC)) begin
        decExp_r <= (wrData[3:0] > `AQ_DEC_EXP_MAX) ? `AQ_DEC_EXP_MAX : wrData[3:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ampGain <= `AQ_GAIN_R0;
    end else begin
      case (gainSel[1:0])
        2'h0:    ampGain <= `AQ_GAIN_R0;
        2'h1:    ampGain <= `AQ_GAIN_R1;
        2'h2:    ampGain <= `AQ_GAIN_R2;
        default: ampGain <= `AQ_GAIN_R3;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timebases
  // ----------------------------------------------------------------
  aqrm_tick_div #(.DIV(LP_DIV)) uLpOsc (
    .mclk (mclk),
    .srst (srst),
    .clr  (1'b0),
    .tick (lpTick)
  );
  aqrm_tick_div #(.DIV(CHOP_HALF_CYC)) uChop (
    .mclk (mclk),
    .srst (srst),
    .clr  (!converting),
    .tick (chopTick)
  );

  // ----------------------------------------------------------------
  // decimation and reporting
  // ----------------------------------------------------------------
  assign converting = (state_r == ST_RUN) || (state_r == ST_SB_MEAS);
  assign ratioM1 = 15'((16'h0001 << decExp_r) - 16'h0001);
  assign outEvt  = chopTick && (decCnt_r == ratioM1);
  // settling samples never count, since the decimator only runs in measure
  assign report  = outEvt && ((state_r == ST_RUN) ||
                   (state_r == ST_SB_MEAS && sbCnt_r == `AQ_SB_LAST_IDX));

  always_ff @(posedge mclk) begin
    if (srst || !converting) begin
      decCnt_r <= 15'h0000;
      sbCnt_r  <= 2'h0;
    end else if (chopTick) begin
      decCnt_r <= (decCnt_r == ratioM1) ? 15'h0000 : decCnt_r + 15'h0001;
      if (outEvt) begin
        sbCnt_r <= sbCnt_r + 2'h1;
      end
    end
  end

  // a gain write landing with a sample still taints the next one
  always_ff @(posedge mclk) begin
    if (srst || devRst_r || measRst_r) begin
      skip_r <= 1'b0;
    end else if (gainChg && converting) begin
      skip_r <= 1'b1;
    end else if (outEvt) begin
      skip_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || devRst_r || measRst_r) begin
      curData_r <= 16'h0000;
      volData_r <= 16'h0000;
      ready_r   <= 1'b0;
      invalid_r <= 1'b0;
    end else if (report) begin
      curData_r <= convCurrent;
      volData_r <= convVoltage;
      ready_r   <= 1'b1;
      invalid_r <= skip_r;
    end else if (statusRd) begin
      ready_r   <= 1'b0;
      invalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // operating state
  // ----------------------------------------------------------------
  logic sbStart;
  assign sbStart = modeWr && wrData[`AQ_MODE_START] && (wrData[7:6] == `AQ_MODE_TIMED_LOW_POWER_MODE);
  assign secDone = lpTick && (lpCnt_r == LW'(LP_PER_S - 1)) &&
                   ({1'b0, secCnt_r} + 9'h001 >= {1'b0, sbPer_r});

  always_ff @(posedge mclk) begin
    if (srst || devRst_r) begin
      state_r <= ST_INIT;
    end else begin
      case (state_r)
        ST_INIT: if (initCnt_r == IW'(INIT_CYC - 1)) state_r <= ST_STOP;
        ST_STOP: if (sbStart) begin
          state_r <= ST_SB_WAIT;
        end else if (modeWr && wrData[`AQ_MODE_START]) begin
          state_r <= ST_RUN;
        end
        ST_RUN: if (modeWr && !wrData[`AQ_MODE_START]) state_r <= ST_STOP;
        ST_SB_WAIT: if (modeWr && !sbStart) begin
          state_r <= ST_STOP;
        end else if (secDone) begin
          state_r <= ST_SB_SETTLE;
        end
        ST_SB_SETTLE: if (modeWr && !sbStart) begin
          state_r <= ST_STOP;
        end else if (settleCnt_r == SW'(SETTLE_CYC - 1)) begin
          state_r <= ST_SB_MEAS;
        end
        ST_SB_MEAS: if (modeWr && !sbStart) begin
          state_r <= ST_STOP;
        end else if (report) begin
          state_r <= ST_SB_WAIT;
        end
        default: state_r <= ST_STOP;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || devRst_r || state_r != ST_INIT) initCnt_r <= '0;
    else initCnt_r <= initCnt_r + IW'(1);
  end
  always_ff @(posedge mclk) begin
    if (srst || state_r != ST_SB_SETTLE) settleCnt_r <= '0;
    else settleCnt_r <= settleCnt_r + SW'(1);
  end
  always_ff @(posedge mclk) begin
    if (srst || state_r != ST_SB_WAIT) begin
      lpCnt_r  <= '0;
      secCnt_r <= 8'h00;
    end else if (lpTick) begin
      if (lpCnt_r == LW'(LP_PER_S - 1)) begin
        lpCnt_r  <= '0;
        secCnt_r <= secCnt_r + 8'h01;
      end else begin
        lpCnt_r <= lpCnt_r + LW'(1);
      end
    end
  end

  assign adcEnable = state_r inside {ST_RUN, ST_SB_SETTLE, ST_SB_MEAS};
  assign lpOscSel  = (state_r == ST_SB_WAIT);

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || devRst_r) begin
      intBusy_r <= 1'b0;
      intCnt_r  <= 3'h0;
      lpTog_r   <= 1'b0;
      intOut    <= 1'b0;
    end else begin
      if (report) begin
        intBusy_r <= 1'b1;
        intCnt_r  <= 3'h0;
      end else if (intBusy_r && lpTick) begin
        intCnt_r <= intCnt_r + 3'h1;
        if (intCnt_r == `AQ_INT_LAST) intBusy_r <= 1'b0;
      end
      if (state_r == ST_INIT && lpTick) lpTog_r <= !lpTog_r;
      intOut <= (state_r == ST_INIT) ? lpTog_r : intBusy_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // cycles since conversion began, so rate checks do not lean on decCnt_r
  logic [31:0] convCyc_r, outPer;
  assign outPer = 32'(CHOP_HALF_CYC) << decExp_r;
  always_ff @(posedge mclk) begin
    if (srst || !converting) convCyc_r <= 32'h0;
    else convCyc_r <= convCyc_r + 32'h1;
  end

  sequence gainWrRun;
    gainChg && converting && !outEvt;
  endsequence
  sequence sbEnter;
    state_r == ST_STOP && sbStart;
  endsequence

  init_end_a: assert property (@(posedge mclk) disable iff (srst)
    state_r == ST_INIT && initCnt_r == IW'(INIT_CYC - 1) && !devRst_r |=> state_r == ST_STOP)
    else $error("init window length wrong");
  soft_reset_a: assert property (@(posedge mclk) disable iff (srst)
    devRst_r |=> state_r == ST_INIT && initCnt_r == '0)
    else $error("device soft reset did not restart init");
  init_lock_a: assert property (@(posedge mclk) disable iff (srst)
    wrStb && state_r == ST_INIT && wrAddr == `AQ_OFS_GAIN |=> $stable(gainSel))
    else $error("write accepted during init");
  run_cfg_lock_a: assert property (@(posedge mclk) disable iff (srst)
    wrStb && state_r == ST_RUN && wrAddr == `AQ_OFS_DEC && !measRst_r |=> $stable(decExp_r))
    else $error("decimation changed while running");
  live_gain_a: assert property (@(posedge mclk) disable iff (srst)
    wrStb && state_r == ST_RUN && wrAddr == `AQ_OFS_GAIN && !measRst_r && !devRst_r
    |=> gainSel == $past(wrData) && state_r == ST_RUN)
    else $error("live gain write not taken");
  gain_taint_a: assert property (@(posedge mclk) disable iff (srst || devRst_r || measRst_r)
    gainWrRun |=> skip_r)
    else $error("sample after gain change not marked invalid");
  int_width_a: assert property (@(posedge mclk) disable iff (srst || devRst_r)
    $fell(intBusy_r) && !$past(srst) && !$past(devRst_r)
    |-> $past(intCnt_r) == `AQ_INT_LAST && $past(lpTick))
    else $error("interrupt pulse not eight slow ticks");
  status_clear_a: assert property (@(posedge mclk) disable iff (srst)
    statusRd && !report |=> !ready_r && !invalid_r)
    else $error("status not cleared by read");
  status_keep_a: assert property (@(posedge mclk) disable iff (srst)
    ready_r && !statusRd && !devRst_r && !measRst_r |=> ready_r)
    else $error("status cleared without read");
  sb_entry_a: assert property (@(posedge mclk) disable iff (srst || devRst_r)
    sbEnter |=> state_r == ST_SB_WAIT ##1 lpOscSel)
    else $error("standby not entered from stop");
  sb_third_a: assert property (@(posedge mclk) disable iff (srst)
    state_r == ST_SB_MEAS |-> report == (convCyc_r == 32'h3 * outPer - 32'h1))
    else $error("standby reported early sample");
  dec_rate_a: assert property (@(posedge mclk) disable iff (srst)
    converting |-> outEvt == (((convCyc_r + 32'h1) % outPer) == 32'h0))
    else $error("output event off decimation boundary");
endmodule
`default_nettype wire

// [aqrm_defs.svh]
`ifndef AQRM_DEFS_SVH
`define AQRM_DEFS_SVH

// ----------------------------------------------------------------
// clocking and timing
// ----------------------------------------------------------------
`define AQ_CLK_KHZ       100000
`define AQ_LPOSC_KHZ     262
`define AQ_LP_DIV        (`AQ_CLK_KHZ / `AQ_LPOSC_KHZ)
`define AQ_LP_PER_S      262000
`define AQ_INIT_US       500
`define AQ_INIT_CYC      (`AQ_INIT_US * (`AQ_CLK_KHZ / 1000))
`define AQ_SETTLE_MS     2
`define AQ_SETTLE_CYC    (`AQ_SETTLE_MS * `AQ_CLK_KHZ)
`define AQ_CHOP_HZ       2000
`define AQ_CHOP_HALF_CYC ((`AQ_CLK_KHZ * 1000) / (2 * `AQ_CHOP_HZ))
`define AQ_INT_LAST      3'h7
`define AQ_SB_LAST_IDX   2'h2

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define AQ_OFS_MODE   7'h01
`define AQ_OFS_STATUS 7'h02
`define AQ_OFS_SBPER  7'h03
`define AQ_OFS_DEC    7'h04
`define AQ_OFS_RST    7'h09
`define AQ_OFS_CURH   7'h0a
`define AQ_OFS_CURL   7'h0b
`define AQ_OFS_VOLH   7'h0c
`define AQ_OFS_VOLL   7'h0d
`define AQ_OFS_GAIN   7'h13
`define AQ_OFS_BYP    7'h15
`define AQ_OFS_VSEL   7'h17
`define AQ_OFS_ISRC   7'h18

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define AQ_RST_DEV_BIT   7
`define AQ_RST_MEAS_BIT  6
`define AQ_RST_READ      8'hc0
`define AQ_MODE_START    0
`define AQ_MODE_TIMED_LOW_POWER_MODE     2'h2
`define AQ_ST_READY      0
`define AQ_ST_INVALID    1
`define AQ_ST_STANDBY    2
`define AQ_ST_RUN        3
`define AQ_SBPER_RST     8'h0a
`define AQ_DEC_EXP_RST   4'h2
`define AQ_DEC_EXP_MAX   4'hf
`define AQ_GAIN_R0       7'h64
`define AQ_GAIN_R1       7'h28
`define AQ_GAIN_R2       7'h19
`define AQ_GAIN_R3       7'h05

`endif

// [aqrm_host_model.sv]
`default_nettype none
module aqrm_host_model (
  // clock
  input  wire logic mclk,
  // serial register port
  output logic      spiCsN,
  output logic      spiSclk,
  output logic      spiMosi,
  input  wire logic spiMiso
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spiCsN  = 1'b1;
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end

  // one whole 16-bit frame; sclk only runs inside it, 80 ns per phase
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {rw, a, wd};
    rd = 8'h00;
    @(negedge mclk) spiCsN = 1'b0;
    repeat (4) @(negedge mclk);
    for (int i = 15; i >= 0; i--) begin
      spiMosi = sh[i];
      repeat (8) @(negedge mclk);
      spiSclk = 1'b1;
      if (i < 8) rd = {rd[6:0], spiMiso};
      repeat (8) @(negedge mclk);
      spiSclk = 1'b0;
    end
    repeat (4) @(negedge mclk);
    spiCsN = 1'b1;
    // released data line must not keep its last value
    spiMosi = ~spiMosi;
    repeat (6) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// [aqrm_pkg.sv]
`default_nettype none
package aqrm_pkg;
  typedef enum logic [2:0] {
    ST_INIT, ST_STOP, ST_RUN, ST_SB_WAIT, ST_SB_SETTLE, ST_SB_MEAS
  } aqrm_state_t;
endpackage
`default_nettype wire

// [aqrm_tick_div.sv]
`default_nettype none
module aqrm_tick_div
  import aqrm_pkg::*;
#(
  parameter int DIV = 381
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // control
  input  wire logic clr,
  // tick out
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_r;

  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign tick = !clr && (cnt_r == LAST);
endmodule
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
  import aqrm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk, srst, csN, sclk, mosi, miso, misoOe, adcEn, lpSel, mpRst, intOut;
  logic [6:0] ampGain;
  logic [7:0] gainSel, bypassCtl, vinSel, isrcCtl, rd;
  logic [15:0] convCur, convVol;
  time        tRise, tPrev;
  int         mismatches, checks_done, n, w, mpCnt;

  aqrm_host_model host (.mclk(mclk), .spiCsN(csN), .spiSclk(sclk), .spiMosi(mosi),
                        .spiMiso(miso));
  // init shortened to 600 cycles, still long enough for a frame to land inside it
  aqrm_ctrl #(.INIT_CYC(600), .SETTLE_CYC(100), .CHOP_HALF_CYC(20), .LP_PER_S(10),
              .LP_DIV(8)) uut (
    .mclk(mclk), .srst(srst), .spiCsN(csN), .spiSclk(sclk), .spiMosi(mosi),
    .spiMiso(miso), .spiMisoOe(misoOe), .convCurrent(convCur), .convVoltage(convVol),
    .adcEnable(adcEn), .lpOscSel(lpSel), .measPathRst(mpRst), .ampGain(ampGain),
    .gainSel(gainSel), .bypassCtl(bypassCtl), .vinSel(vinSel), .isrcCtl(isrcCtl),
    .intOut(intOut));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // path reset pulse is one cycle wide, so it is counted once per cycle
  always @(negedge mclk) begin
    if (mpRst === 1'b1) mpCnt++;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t byte %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t bit %b expected %b", $time, g, e);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, rd);
    chk8(rd, e);
  endtask

  // waits for a data-ready pulse and measures it in mclk cycles
  task automatic wait_int(input int lim);
    n = 0;
    w = 0;
    while (intOut !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    tPrev = tRise;
    tRise = $time;
    chkb(n < lim, 1'b1);
    while (intOut === 1'b1 && w < 200) begin
      @(negedge mclk);
      w++;
    end
  endtask

  initial begin
    #600us;
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    logic [7:0] gTab [4];
    gTab = '{8'h64, 8'h28, 8'h19, 8'h05};
    convCur = 16'h1234;
    convVol = 16'h5678;
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    wr(7'h13, 8'h03);
    chk8(gainSel, 8'h00);
    chkb(misoOe, 1'b0);
    repeat (400) @(negedge mclk);
    rdc(7'h09, 8'hc0);
    wr(7'h04, 8'h08);
    for (int g = 0; g < 4; g++) begin
      wr(7'h13, 8'(g));
      chk8({1'b0, ampGain}, gTab[g]);
    end
    wr(7'h01, 8'h01);
    chkb(adcEn, 1'b1);
    wr(7'h04, 8'h03);
    rdc(7'h04, 8'h08);
    wr(7'h13, 8'h00);
    wr(7'h17, 8'h5a);
    chk8(vinSel, 8'h5a);
    wr(7'h15, 8'h3c);
    chk8(bypassCtl, 8'h3c);
    chk8({1'b0, ampGain}, 8'h64);
    wait_int(6000);
    chkb(w >= 56 && w <= 72, 1'b1);
    rdc(7'h02, 8'h0b);
    rdc(7'h02, 8'h08);
    // data of the first pulse after the gain change is discarded
    wait_int(6000);
    // ratio 2^8 of 20-cycle chop halves, 10 ns per cycle
    chkb((tRise - tPrev) == 64'd51200, 1'b1);
    rdc(7'h02, 8'h09);
    rdc(7'h0a, 8'h12);
    rdc(7'h0d, 8'h78);
    wr(7'h01, 8'h00);
    chkb(adcEn, 1'b0);
    // no external clock runs here, so nothing to gate for soft reset
    wr(7'h09, 8'hbf);
    rdc(7'h04, 8'h02);
    chk8(vinSel, 8'h00);
    chk8(bypassCtl, 8'h00);
    chk8(8'(mpCnt), 8'h01);
    convCur = 16'h9abc;
    wr(7'h03, 8'h01);
    wr(7'h01, 8'h81);
    chkb(lpSel, 1'b1);
    chkb(adcEn, 1'b0);
    wait_int(3000);
    chkb(lpSel, 1'b1);
    rdc(7'h02, 8'h05);
    rdc(7'h0b, 8'hbc);
    wait_int(3000);
    wr(7'h01, 8'h00);
    chkb(lpSel, 1'b0);
    rdc(7'h30, 8'h00);
    wr(7'h18, 8'h33);
    chk8(isrcCtl, 8'h33);
    wr(7'h09, 8'h7f);
    chk8(isrcCtl, 8'h00);
    chk8(8'(mpCnt), 8'h01);
    n = 0;
    for (int c = 0; c < 64; c++) begin
      w = intOut;
      @(negedge mclk);
      if (intOut !== w[0]) n++;
    end
    chkb(n >= 7 && n <= 9, 1'b1);
    repeat (700) @(negedge mclk);
    rdc(7'h09, 8'hc0);
    give_verdict();
  end
endmodule
`default_nettype wire
